// [dtr_ctrl.sv]
// DRAM access sequencer with programmable intervals and refresh scheduler.
// Assumes requests and the register bus share CLK_IN; only RESET_IN is asynchronous.
// What this block does
// - Read and write accesses use the same programmed interval set.
// - All strobe transitions leave flip-flops on the rising clock edge.
// - Bursts are four beats on 64-bit path, eight on 32-bit path.
// - Beats run sequentially from the critical word, wrapping in the line.
// - Column strobe waits the row-to-column delay after row strobe.
// - First or single beat holds column strobe for its own interval.
// - Column strobe negates for column precharge between page beats.
// - Later page beats hold column strobe for the page-beat interval.
// - Refresh holds the row strobe for the refresh width interval.
// - Refreshes repeat every refresh interval count plus one bus clocks.
// - A refresh due during a burst waits until the access completes.
// - From idle, first data follows transfer start after programmed delays.
// - Refresh interval count sits in bits 15 to 2 of config two.
// - Config three holds the six interval fields at fixed positions.
// - Setting memory go runs eight spaced refreshes before accesses.
// - Refresh width counts clocks with row strobe held asserted.
`timescale 1ns/10ps
module dtr_ctrl
  import dtr_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [3:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [3:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  input wire logic TRANSFER_START_IN,
  input wire logic ACCESS_WRITE_IN,
  input wire logic ACCESS_BURST_IN,
  input wire logic [1:0] CRIT_DWORD_IN,
  output logic ACCESS_ACCEPT_OUT,
  output logic ACCESS_DONE_OUT,
  output logic ROW_STROBE_N_OUT,
  output logic COL_STROBE_N_OUT,
  output logic WRITE_EN_N_OUT,
  output logic BEAT_STROBE_OUT,
  output logic [2:0] BEAT_INDEX_OUT,
  output logic MEM_READY_OUT
);
  // Interval to down-counter load; a zero field still gives one cycle
  function automatic logic [3:0] load_of(input logic [3:0] v);
    load_of = (v == 4'h0) ? 4'h0 : v - 4'h1;
  endfunction
  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    merge = r & msk;
  endfunction

  logic [31:0] ctrl_q, cfg2_q, cfg3_q, rdata_q;
  logic [3:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  dtr_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d, init_left_q, init_left_d;
  logic [2:0] left_q, left_d, beat_q, beat_d;
  logic ras_n_q, ras_n_d, cas_n_q, cas_n_d, we_n_q, we_n_d;
  logic strobe_q, strobe_d, accept_q, accept_d, done_q, done_d;
  logic [13:0] ref_tmr_q;
  logic pend_q, started_q, ready_q;

  // Field decode of the configuration registers
  wire go = ctrl_q[GO_BIT];
  wire w32 = ctrl_q[W32_BIT];
  wire [13:0] refresh_interval_count = cfg2_q[REFRESH_INTERVAL_COUNT_MSB:REFRESH_INTERVAL_COUNT_LSB];
  wire [3:0] rp = {1'b0, cfg3_q[RP_LSB +: 3]};
  wire [3:0] rcd = {1'b0, cfg3_q[RCD_LSB +: 3]};
  wire [3:0] first_beat_column_width = {1'b0, cfg3_q[FIRST_BEAT_COLUMN_WIDTH_LSB +: 3]};
  wire [3:0] cp4 = {1'b0, cfg3_q[CP4_LSB +: 3]};
  wire [3:0] page_beat_column_width = {1'b0, cfg3_q[PAGE_BEAT_COLUMN_WIDTH_LSB +: 3]};
  wire [3:0] ras6 = cfg3_q[RAS6_LSB +: 4];

  // Bus handshake decode
  wire aw_take = AWVALID_IN & awready_q;
  wire w_take = WVALID_IN & wready_q;
  wire ar_take = ARVALID_IN & arready_q;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = aw_full_q ? ~do_write : aw_take;
  wire w_full_d = w_full_q ? ~do_write : w_take;
  wire bvalid_d = do_write | (bvalid_q & ~BREADY_IN);
  wire rvalid_d = ar_take | (rvalid_q & ~RREADY_IN);
  wire wr_ctrl = do_write & (aw_addr_q == ADDR_CTRL);
  wire wr_cfg2 = do_write & (aw_addr_q == ADDR_CFG2);
  wire wr_cfg3 = do_write & (aw_addr_q == ADDR_CFG3);
  wire wr_ok = wr_ctrl | wr_cfg2 | wr_cfg3 | (aw_addr_q == ADDR_STAT);
  wire [31:0] status = {24'h0000_00, init_left_q, 1'b0, pend_q, state_q != S_IDLE, ready_q};
  wire rd_ok = (ARADDR_IN[3:2] <= ADDR_STAT[3:2]);
  wire [31:0] rd_mux = (ARADDR_IN == ADDR_CTRL) ? ctrl_q :
                       (ARADDR_IN == ADDR_CFG2) ? cfg2_q :
                       (ARADDR_IN == ADDR_CFG3) ? cfg3_q :
                       (ARADDR_IN == ADDR_STAT) ? status : REG_RESET;

  // Register bus slave and configuration registers
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      {aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q} <= '0;
      {aw_addr_q, wdata_q, wstrb_q, rdata_q, bresp_q, rresp_q} <= '0;
      ctrl_q <= REG_RESET;
      cfg2_q <= REG_RESET;
      cfg3_q <= REG_RESET;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (aw_take) aw_addr_q <= {AWADDR_IN[3:2], 2'b00};
      if (w_take) wdata_q <= WDATA_IN;
      if (w_take) wstrb_q <= WSTRB_IN;
      if (do_write) bresp_q <= wr_ok ? RESP_OKAY : RESP_DECERR;
      if (ar_take) rdata_q <= rd_mux;
      if (ar_take) rresp_q <= rd_ok ? RESP_OKAY : RESP_DECERR;
      if (wr_ctrl) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q, CTRL_MASK);
      if (wr_cfg2) cfg2_q <= merge(cfg2_q, wdata_q, wstrb_q, CFG2_MASK);
      if (wr_cfg3) cfg3_q <= merge(cfg3_q, wdata_q, wstrb_q, CFG3_MASK);
    end
  end

  // Refresh timer; a new due refresh wins over the take in the same cycle
  wire ref_fire = started_q & (ref_tmr_q == 14'h0000);
  wire ref_take = (state_q == S_IDLE) & pend_q & started_q;
  wire [2:0] last_beat = w32 ? LAST_BEAT_32 : LAST_BEAT_64;
  wire [2:0] start_beat = w32 ? {CRIT_DWORD_IN, 1'b0} : {1'b0, CRIT_DWORD_IN};
  wire [2:0] beat_inc = beat_q + 3'h1;
  wire [2:0] beat_next = beat_inc & last_beat;
  wire cnt_end = (cnt_q == 4'h0);

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ref_tmr_q <= '0;
      pend_q <= 1'b0;
      started_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      started_q <= go;
      ref_tmr_q <= (~started_q | ref_fire) ? refresh_interval_count : ref_tmr_q - 14'h0001;
      pend_q <= started_q & (ref_fire | (pend_q & ~ref_take));
      ready_q <= go & started_q & (init_left_d == 4'h0);
    end
  end

  // Sequencer next state: access and refresh timing
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_end ? cnt_q : cnt_q - 4'h1;
    left_d = left_q;
    beat_d = beat_q;
    ras_n_d = ras_n_q;
    cas_n_d = cas_n_q;
    we_n_d = we_n_q;
    strobe_d = 1'b0;
    accept_d = 1'b0;
    done_d = 1'b0;
    init_left_d = (go & ~started_q) ? INIT_REFRESHES : init_left_q;
    unique case (state_q)
      S_IDLE: begin
        if (ref_take) begin
          state_d = S_RCAS;
          cas_n_d = 1'b0;
        end else if (TRANSFER_START_IN & ready_q) begin
          state_d = S_RCD;
          ras_n_d = 1'b0;
          we_n_d = ~ACCESS_WRITE_IN;
          cnt_d = load_of(rcd);
          left_d = ACCESS_BURST_IN ? last_beat : 3'h0;
          beat_d = start_beat;
          accept_d = 1'b1;
        end
      end
      S_RCD: begin
        if (cnt_end) begin
          state_d = S_CAS;
          cas_n_d = 1'b0;
          cnt_d = load_of(first_beat_column_width);
          strobe_d = 1'b1;
        end
      end
      S_CAS: begin
        if (cnt_end && left_q != 3'h0) begin
          state_d = S_CP;
          cas_n_d = 1'b1;
          cnt_d = load_of(cp4);
        end else if (cnt_end) begin
          state_d = S_PRE;
          {ras_n_d, cas_n_d, we_n_d} = 3'b111;
          cnt_d = load_of(rp);
          done_d = 1'b1;
        end
      end
      S_CP: begin
        if (cnt_end) begin
          state_d = S_CAS;
          cas_n_d = 1'b0;
          cnt_d = load_of(page_beat_column_width);
          beat_d = beat_next;
          left_d = left_q - 3'h1;
          strobe_d = 1'b1;
        end
      end
      S_RCAS: begin
        state_d = S_RRAS;
        ras_n_d = 1'b0;
        cnt_d = load_of(ras6);
      end
      S_RRAS: begin
        if (cnt_end) begin
          state_d = S_PRE;
          {ras_n_d, cas_n_d} = 2'b11;
          cnt_d = load_of(rp);
          if (init_left_q != 4'h0) init_left_d = init_left_q - 4'h1;
        end
      end
      S_PRE: begin
        if (cnt_end) state_d = S_IDLE;
      end
    endcase
    if (~go) init_left_d = 4'h0;
  end

  // Sequencer registers; every DRAM strobe is a flop output
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_q <= S_IDLE;
      {cnt_q, init_left_q, left_q, beat_q} <= '0;
      {ras_n_q, cas_n_q, we_n_q} <= 3'b111;
      {strobe_q, accept_q, done_q} <= 3'b000;
    end else begin
      state_q <= state_d;
      {cnt_q, init_left_q, left_q, beat_q} <= {cnt_d, init_left_d, left_d, beat_d};
      {ras_n_q, cas_n_q, we_n_q} <= {ras_n_d, cas_n_d, we_n_d};
      {strobe_q, accept_q, done_q} <= {strobe_d, accept_d, done_d};
    end
  end

  // Output drive
  assign AWREADY_OUT = awready_q;
  assign WREADY_OUT = wready_q;
  assign BRESP_OUT = bresp_q;
  assign BVALID_OUT = bvalid_q;
  assign ARREADY_OUT = arready_q;
  assign RDATA_OUT = rdata_q;
  assign RRESP_OUT = rresp_q;
  assign RVALID_OUT = rvalid_q;
  assign ACCESS_ACCEPT_OUT = accept_q;
  assign ACCESS_DONE_OUT = done_q;
  assign ROW_STROBE_N_OUT = ras_n_q;
  assign COL_STROBE_N_OUT = cas_n_q;
  assign WRITE_EN_N_OUT = we_n_q;
  assign BEAT_STROBE_OUT = strobe_q;
  assign BEAT_INDEX_OUT = beat_q;
  assign MEM_READY_OUT = ready_q;

  // Checking helpers: cycles spent in the current state, beats per access
  logic [3:0] phase_q;
  logic [3:0] beats_q;
  logic first_q;
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      phase_q <= 4'h1;
      beats_q <= 4'h0;
      first_q <= 1'b0;
    end else begin
      phase_q <= (state_d != state_q) ? 4'h1 : phase_q + {3'h0, phase_q != 4'hF};
      beats_q <= accept_d ? 4'h0 : beats_q + {3'h0, strobe_d};
      first_q <= (state_q == S_RCD) ? 1'b1 : (state_q == S_CP) ? 1'b0 : first_q;
    end
  end
  wire [3:0] want_len = (state_q == S_RCD) ? (rcd | {3'h0, rcd == 4'h0}) :
                        (state_q == S_CP) ? (cp4 | {3'h0, cp4 == 4'h0}) :
                        (state_q == S_RRAS) ? (ras6 | {3'h0, ras6 == 4'h0}) :
                        first_q ? (first_beat_column_width | {3'h0, first_beat_column_width == 4'h0}) : (page_beat_column_width | {3'h0, page_beat_column_width == 4'h0});
  wire leaving = (state_q != state_d);

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  a_rcd_delay: assert property (state_q == S_RCD && leaving |-> phase_q == want_len)
    else $error("row to column delay wrong");
  a_first_width: assert property (state_q == S_CAS && first_q && leaving |-> phase_q == want_len)
    else $error("first beat column width wrong");
  a_page_prech: assert property (state_q == S_CP && leaving |-> phase_q == want_len && cas_n_q)
    else $error("column precharge wrong");
  a_page_width: assert property (state_q == S_CAS && !first_q && leaving |-> phase_q == want_len)
    else $error("page beat column width wrong");
  a_ref_width: assert property (state_q == S_RRAS && leaving |-> phase_q == want_len && !ras_n_q)
    else $error("refresh row strobe width wrong");
  a_burst_len: assert property (done_q |-> beats_q == 4'h1 || beats_q == {1'b0, last_beat} + 4'h1)
    else $error("burst beat count wrong");
  a_wrap_order: assert property (strobe_q && state_q == S_CAS && !first_q |->
    beat_q == (($past(beat_q) + 3'h1) & last_beat))
    else $error("beat order wrong");
  a_ref_defer: assert property (state_q inside {S_RCD, S_CAS, S_CP} |=> state_q != S_RCAS)
    else $error("refresh broke into access");
  a_ref_resume: assert property (done_q && pend_q && go |-> ##[1:8] state_q == S_RCAS)
    else $error("deferred refresh not performed");
  a_init_refresh: assert property ($rose(ready_q) |-> init_left_q == 4'h0 && go)
    else $error("ready before init refreshes");
  a_ref_pending: assert property (ref_fire && state_q == S_IDLE |=> pend_q)
    else $error("due refresh not flagged");

  c_burst: cover property (done_q && beats_q > 4'h1);
  c_single_write: cover property (accept_q && !we_n_q ##[1:60] done_q);
  c_ref_deferred: cover property (pend_q && state_q == S_CAS);
  c_ready: cover property ($rose(ready_q));
endmodule

// [dtr_pkg.sv]
// Constants for the DRAM timing and refresh sequencer.
// Assumes a single 100 MHz clock and AXI4-Lite register access.
package dtr_pkg;
  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CFG2 = 4'h4;
  localparam logic [3:0] ADDR_CFG3 = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;
  // Control register bits
  localparam int GO_BIT = 0;
  localparam int W32_BIT = 1;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
  // Second config register field
  localparam int REFRESH_INTERVAL_COUNT_LSB = 2;
  localparam int REFRESH_INTERVAL_COUNT_MSB = 15;
  // Third config register fields
  localparam int RP_LSB = 0;
  localparam int RCD_LSB = 3;
  localparam int FIRST_BEAT_COLUMN_WIDTH_LSB = 6;
  localparam int CP4_LSB = 9;
  localparam int PAGE_BEAT_COLUMN_WIDTH_LSB = 12;
  localparam int RAS6_LSB = 15;
  localparam logic [31:0] CFG2_MASK = 32'h0000_FFFC;
  localparam logic [31:0] CFG3_MASK = 32'h0007_FFFF;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Status register bits
  localparam int ST_READY = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_PEND = 2;
  localparam int ST_INIT_LSB = 4;
  // Sequencing constants
  localparam logic [3:0] INIT_REFRESHES = 4'h8;
  localparam logic [2:0] LAST_BEAT_64 = 3'h3;
  localparam logic [2:0] LAST_BEAT_32 = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {S_IDLE, S_RCD, S_CAS, S_CP, S_PRE, S_RCAS, S_RRAS} dtr_state_t;
endpackage

// [dtr_dram_model.sv]
// Behavioural DRAM bank that times the strobes it is given.
// Assumes active low strobes launched on the rising edge of clk_in.
`timescale 1ns/10ps
module dtr_dram_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic row_n_in,
  input wire logic col_n_in,
  input wire logic we_n_in,
  output logic [7:0] refs_out,
  output logic [7:0] beats_out,
  output logic [7:0] rcd_out,
  output logic [7:0] fw_out,
  output logic [7:0] cp_out,
  output logic [7:0] pw_out,
  output logic [7:0] rw_out,
  output logic [15:0] gap_out,
  output logic we_out
);
  logic row_q, col_q, in_ref;
  logic [7:0] rl, cl, ch;
  logic [15:0] t, t_ref;
  // Strobe edges seen at the sampling clock
  wire col_fall = col_q && !col_n_in;
  wire col_rise = !col_q && col_n_in;
  wire row_fall = row_q && !row_n_in;
  wire row_rise = !row_q && row_n_in;
  // Run lengths of strobe levels in whole clocks
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      row_q <= 1'b1;
      col_q <= 1'b1;
      in_ref <= 1'b0;
      rl <= 8'h00;
      cl <= 8'h00;
      ch <= 8'h00;
      t <= 16'h0000;
      refs_out <= 8'h00;
    end else begin
      row_q <= row_n_in;
      col_q <= col_n_in;
      t <= t + 16'h0001;
      rl <= row_n_in ? 8'h00 : rl + 8'h01;
      cl <= col_n_in ? 8'h00 : cl + 8'h01;
      ch <= col_n_in ? ch + 8'h01 : 8'h00;
      // Row falling behind a low column is a refresh
      if (row_fall && !col_q) begin
        in_ref <= 1'b1;
        gap_out <= t - t_ref;
        t_ref <= t;
      end
      if (row_fall && col_q) beats_out <= 8'h00;
      if (row_rise && in_ref) begin
        in_ref <= 1'b0;
        rw_out <= rl;
        refs_out <= refs_out + 8'h01;
      end
      // Column low inside an access opens a beat
      if (col_fall && !row_n_in) begin
        beats_out <= beats_out + 8'h01;
        we_out <= we_n_in;
        if (beats_out == 8'h00) rcd_out <= rl;
        else cp_out <= ch;
      end
      if (col_rise && !in_ref) begin
        if (beats_out == 8'h01) fw_out <= cl;
        else pw_out <= cl;
      end
    end
  end
endmodule

// [dtr_ctrl_tb.sv]
// Self-checking bench for the DRAM timing and refresh sequencer.
// Assumes dtr_pkg, dtr_ctrl and dtr_dram_model are compiled first.
`timescale 1ns/10ps
module dtr_ctrl_tb
  import dtr_pkg::*;
;
  localparam logic [7:0] V_RP = 8'h02, V_RCD = 8'h02, V_FBW = 8'h03, V_PCP = 8'h01;
  localparam logic [7:0] V_PBW = 8'h02, V_RSW = 8'h03, V_RI = 8'h28;
  // Interval fields above packed at their bit positions
  localparam logic [31:0] CFG3 = 32'h0001_A2D2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic xs = 1'b0, aw = 1'b0, ab = 1'b0;
  logic [3:0] awa = 4'h0, ws = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [1:0] cr = 2'h0;
  logic awr, wr_r, bv, arr, rv, acc_o, dn, row_n, col_n, we_n, bs, rdy, m_we;
  logic [1:0] bresp, rresp;
  logic [2:0] bi;
  logic [31:0] rdat, d;
  logic [7:0] m_ref, m_beats, m_rcd, m_fw, m_cp, m_pw, m_rw, r_s;
  logic [15:0] m_gap;
  logic [2:0] idxq[$];
  int err_total, checked, cyc, i;

  dtr_ctrl dut (.CLK_IN(clk), .RESET_IN(rst), .AWADDR_IN(awa), .AWVALID_IN(awv),
    .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(ws), .WVALID_IN(wv), .WREADY_OUT(wr_r),
    .BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(br), .ARADDR_IN(ara), .ARVALID_IN(arv),
    .ARREADY_OUT(arr), .RDATA_OUT(rdat), .RRESP_OUT(rresp), .RVALID_OUT(rv), .RREADY_IN(rr),
    .TRANSFER_START_IN(xs), .ACCESS_WRITE_IN(aw), .ACCESS_BURST_IN(ab), .CRIT_DWORD_IN(cr),
    .ACCESS_ACCEPT_OUT(acc_o), .ACCESS_DONE_OUT(dn), .ROW_STROBE_N_OUT(row_n),
    .COL_STROBE_N_OUT(col_n), .WRITE_EN_N_OUT(we_n), .BEAT_STROBE_OUT(bs),
    .BEAT_INDEX_OUT(bi), .MEM_READY_OUT(rdy));
  dtr_dram_model mem (.clk_in(clk), .rst_in(rst), .row_n_in(row_n), .col_n_in(col_n),
    .we_n_in(we_n), .refs_out(m_ref), .beats_out(m_beats), .rcd_out(m_rcd), .fw_out(m_fw),
    .cp_out(m_cp), .pw_out(m_pw), .rw_out(m_rw), .gap_out(m_gap), .we_out(m_we));

  always #5 clk = ~clk;
  // Beat order as announced by the sequencer
  always @(posedge clk) begin
    if (bs === 1'b1) idxq.push_back(bi);
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // AXI4-Lite write, address and data offered together
  task automatic wrr(input logic [3:0] a, input logic [31:0] v);
    awa <= a;
    wd <= v;
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wr_r === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) begin
        chk(bresp, RESP_OKAY);
        break;
      end
    end
    br <= 1'b0;
    @(posedge clk);
  endtask
  // AXI4-Lite read
  task automatic rdr(input logic [3:0] a, output logic [31:0] v);
    v = 32'hxxxx_xxxx;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) begin
        v = rdat;
        chk(rresp, RESP_OKAY);
        break;
      end
    end
    rr <= 1'b0;
    @(posedge clk);
  endtask
  // One access, then the strobe timing and beat order are judged
  task automatic acc(input logic w, input logic b, input logic [1:0] c, input logic h);
    int nb;
    logic [7:0] r0;
    nb = b ? (h ? 8 : 4) : 1;
    idxq.delete();
    xs <= 1'b1;
    aw <= w;
    ab <= b;
    cr <= c;
    while (acc_o !== 1'b1) @(posedge clk);
    xs <= 1'b0;
    r0 = m_ref;
    while (dn !== 1'b1) @(posedge clk);
    chk(m_ref, r0);
    repeat (V_RP + 3) @(posedge clk);
    chk(m_beats, nb);
    chk(idxq.size(), nb);
    for (int k = 0; k < idxq.size(); k++) chk(idxq[k], h ? (2 * c + k) % 8 : (c + k) % 4);
    chk(m_rcd, V_RCD);
    chk(m_fw, V_FBW);
    chk(m_we, !w);
    if (b) chk(m_cp, V_PCP);
    if (b) chk(m_pw, V_PBW);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 3; i++) begin
      rdr(4'(4 * i), d);
      chk(d, REG_RESET);
    end
    wrr(4'h4, 32'hFFFF_FFFF);
    rdr(4'h4, d);
    chk(d, 32'h0000_FFFC);
    wrr(4'h8, 32'hFFFF_FFFF);
    rdr(4'h8, d);
    chk(d, 32'h0007_FFFF);
    // Intervals set before any access, interval above the longest access
    wrr(4'h4, 32'h0000_00A0);
    wrr(4'h8, CFG3);
    rdr(4'h8, d);
    chk(d, CFG3);
    $display("test registers finished");
    wrr(4'h0, 32'h0000_0001);
    while (rdy !== 1'b1) @(posedge clk);
    // Model counts the last refresh one edge after ready rises
    repeat (2) @(posedge clk);
    chk(m_ref, 8'h08);
    chk(m_rw, V_RSW);
    chk(m_gap, V_RI + 8'h01);
    rdr(4'hC, d);
    chk(d[ST_READY], 1'b1);
    $display("test init finished");
    r_s = m_ref;
    acc(1'b0, 1'b0, 2'h1, 1'b0);
    acc(1'b1, 1'b0, 2'h3, 1'b0);
    for (i = 0; i < 8; i++) begin
      if (i == 4) wrr(4'h0, 32'h0000_0003);
      acc(i[0], 1'b1, i[1:0], i > 3);
    end
    repeat (100) @(posedge clk);
    chk(m_ref > r_s, 1'b1);
    chk(m_rw, V_RSW);
    $display("test accesses finished");
    summarize();
  end
endmodule
